// *** rtl/drpd_top.sv ***
// per-rank clock-enable power-down and unpopulated-rank pin release
// assumes rank request inputs and refresh_req are on clock; mem_clk is not
//
// Summary of operation
// (RL1) float every output of an empty slot
// (RL2) empty rank: chip-select, clock-enable undriven
// (RL3) reset assumes populated; tristate enabled by software
// (RL4) four independent clock-enable outputs
// (RL5) config: kind 15:12, threshold 11:0
// (RL6) kinds: none, open-page, dll-off sleep
// (RL7) open-page sleep keeps pages, exit tXP
// (RL8) dll-off exit waits tXP plus tXPDLL
// (RL9) per-rank decision and idle counter
// (RL10) arrival restarts counter; enter only if unqueued
// (RL11) threshold counts idle memory clock cycles
// (RL12) firmware default 6080h, 128 memory clocks
// (RL13) config writable at run time unless locked
// (RL14) clock-enable low until config written
// (RL15) wake all ranks for refresh, resleep after
// (RL16) arrival wakes rank, commands wait exit delay
// (RL17) unknown kind behaves as no sleep
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module drpd_top
  import drpd_pkg::*;
#(
  parameter logic [5:0] TXP_CYC = TXP_MCLK,
  parameter logic [5:0] TXPDLL_CYC = TXPDLL_MCLK
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic mem_clk,
  input wire logic [NUM_RANKS-1:0] txn_arrive,
  input wire logic [NUM_RANKS-1:0] txn_queued,
  input wire logic [NUM_RANKS-1:0] page_open,
  input wire logic [NUM_RANKS-1:0] cs_n_req,
  input wire logic refresh_req,
  output logic refresh_ready,
  output logic [NUM_RANKS-1:0] cmd_ready,
  output logic [NUM_RANKS-1:0] precharge_req,
  output drpd_pins_t pins
);

  // memory clock sampling
  logic mclk_s1_q, mclk_s2_q, mclk_s3_q;
  logic mclk_rise;

  // registers
  drpd_cfg_t cfg_q;
  logic cfg_seen_q, tristate_q, lock_q;
  logic [NUM_RANKS-1:0] pop_q;
  logic [31:0] rdata_q;
  logic refresh_q;

  // per-rank state
  drpd_state_t st_q [NUM_RANKS];
  drpd_state_t st_d [NUM_RANKS];
  logic [11:0] cnt_q [NUM_RANKS];
  logic [11:0] cnt_d [NUM_RANKS];
  logic [5:0] exit_q [NUM_RANKS];
  logic [5:0] exit_d [NUM_RANKS];
  logic [NUM_RANKS-1:0] dll_q, dll_d;
  logic [NUM_RANKS-1:0] ready_q, ready_d;
  logic [NUM_RANKS-1:0] pchg_q, pchg_d;
  logic [NUM_RANKS-1:0] asleep, awake_d;
  drpd_pins_t pins_q, pins_d;
  logic refresh_ready_q;

  // decode
  wire cfg_wr = wr_en && (addr == REG_SLEEP_CFG) && !lock_q;
  wire ctl_wr = wr_en && (addr == REG_CONTROL);
  wire kind_open = (cfg_q.kind == KIND_OPEN_PAGE);
  wire kind_dll = (cfg_q.kind == KIND_DLL_OFF);
  wire kind_on = kind_open || kind_dll; // RL17
  wire refresh_end = refresh_q && !refresh_req;
  wire [NUM_RANKS-1:0] float_mask = tristate_q ? ~pop_q : '0; // RL3
  wire [NUM_RANKS-1:0] work = txn_arrive | txn_queued;
  wire [5:0] dly_open = TXP_CYC; // RL7
  wire [5:0] dly_dll = 6'(TXP_CYC + TXPDLL_CYC); // RL8

  function automatic logic expired(input logic [11:0] cnt,
                                   input logic [11:0] thr);
    expired = (cnt >= thr); // RL11
  endfunction

  assign mclk_rise = mclk_s2_q && !mclk_s3_q;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
    end else begin
      mclk_s1_q <= mem_clk;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
    end
  end

  // register file
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_q <= CFG_RST;
      cfg_seen_q <= 1'b0;
      tristate_q <= 1'b0;
      lock_q <= 1'b0;
      pop_q <= POP_RST; // RL3
    end else begin
      if (cfg_wr) begin
        cfg_q <= wdata[15:0]; // RL5 RL13
        cfg_seen_q <= 1'b1; // RL14
      end
      if (ctl_wr) begin
        tristate_q <= wdata[CTL_TRISTATE_BIT];
        lock_q <= lock_q | wdata[CTL_LOCK_BIT];
        pop_q <= wdata[CTL_POP_LSB +: NUM_RANKS];
      end
    end
  end

  wire [31:0] ctl_rd = {24'h000000, pop_q, 2'b00, lock_q, tristate_q};
  wire [31:0] sts_rd = {19'h00000, cfg_seen_q, pins_q.cke, ready_q, asleep};
  wire [31:0] rd_mux = (addr == REG_SLEEP_CFG) ? {16'h0000, cfg_q} :
                       (addr == REG_CONTROL) ? ctl_rd :
                       (addr == REG_STATUS) ? sts_rd : 32'h00000000;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rd_en ? rd_mux : 32'h00000000;
    end
  end

  // per-rank sleep decision
  always_comb begin
    for (int i = 0; i < NUM_RANKS; i++) begin
      st_d[i] = st_q[i];
      cnt_d[i] = cnt_q[i];
      exit_d[i] = exit_q[i];
      dll_d[i] = dll_q[i];
      pchg_d[i] = 1'b0;
      asleep[i] = (st_q[i] == DRPD_SLEEP);
      if (work[i]) begin
        cnt_d[i] = 12'h000; // RL10
      end else if (refresh_end) begin
        cnt_d[i] = cfg_q.thr; // RL15
      end else if (mclk_rise && cnt_q[i] != IDLE_SAT) begin
        cnt_d[i] = 12'(cnt_q[i] + 12'h001); // RL9 RL11
      end
      unique case (st_q[i])
        DRPD_AWAKE: begin
          if (cfg_seen_q && kind_on && !work[i] && !refresh_req &&
              expired(cnt_q[i], cfg_q.thr)) begin
            if (kind_open || !page_open[i]) begin
              st_d[i] = DRPD_SLEEP; // RL6 RL10
              dll_d[i] = kind_dll;
            end else begin
              pchg_d[i] = 1'b1; // RL8
            end
          end
        end
        DRPD_SLEEP: begin
          if (work[i] || refresh_req || !kind_on) begin
            st_d[i] = DRPD_EXIT; // RL16 RL15
            exit_d[i] = dll_q[i] ? dly_dll : dly_open; // RL7 RL8
          end
        end
        DRPD_EXIT: begin
          if (exit_q[i] == 6'd0) begin
            st_d[i] = DRPD_AWAKE; // RL16
          end else if (mclk_rise) begin
            exit_d[i] = 6'(exit_q[i] - 6'd1);
          end
        end
        default: begin
          st_d[i] = DRPD_AWAKE;
        end
      endcase
      awake_d[i] = (st_d[i] == DRPD_AWAKE);
      ready_d[i] = awake_d[i];
    end
  end

  // pins: four independent clock-enables, released for empty ranks
  assign pins_d.cke = {NUM_RANKS{cfg_seen_q}} & ~asleep_d(st_d); // RL4 RL14
  assign pins_d.cke_oe_n = float_mask; // RL2
  assign pins_d.cs_n = float_mask | cs_n_req;
  assign pins_d.cs_oe_n = float_mask; // RL1 RL2

  function automatic logic [NUM_RANKS-1:0] asleep_d(input drpd_state_t s
                                                    [NUM_RANKS]);
    for (int k = 0; k < NUM_RANKS; k++) begin
      asleep_d[k] = (s[k] == DRPD_SLEEP);
    end
  endfunction

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_RANKS; i++) begin
        st_q[i] <= DRPD_AWAKE;
        cnt_q[i] <= 12'h000;
        exit_q[i] <= 6'd0;
      end
      dll_q <= '0;
      ready_q <= '0;
      pchg_q <= '0;
      pins_q <= '0;
      refresh_q <= 1'b0;
      refresh_ready_q <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_RANKS; i++) begin
        st_q[i] <= st_d[i];
        cnt_q[i] <= cnt_d[i];
        exit_q[i] <= exit_d[i];
      end
      dll_q <= dll_d;
      ready_q <= ready_d;
      pchg_q <= pchg_d;
      pins_q <= pins_d;
      refresh_q <= refresh_req;
      refresh_ready_q <= refresh_req && (&awake_d); // RL15
    end
  end

  assign rdata = rdata_q;
  assign cmd_ready = ready_q;
  assign precharge_req = pchg_q;
  assign pins = pins_q;
  assign refresh_ready = refresh_ready_q;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_empty_float;
    (tristate_q && !pop_q[1]) |=>
      (pins_q.cke_oe_n[1] && pins_q.cs_oe_n[1] && pins_q.cs_n[1]);
  endproperty
  a_empty_float: assert property (p_empty_float) // RL2
    else $error("empty rank pins still driven");

  property p_driven_until_enabled;
    !tristate_q |=> (pins_q.cke_oe_n == '0 && pins_q.cs_oe_n == '0);
  endproperty
  a_driven_until_enabled: assert property (p_driven_until_enabled) // RL3
    else $error("pins floated before tristate enable");

  property p_cke_low_unconfigured;
    !cfg_seen_q |=> (pins_q.cke == '0);
  endproperty
  a_cke_low_unconfigured: assert property (p_cke_low_unconfigured) // RL14
    else $error("clock-enable raised before config write");

  property p_lock_holds;
    (lock_q && wr_en && addr == REG_SLEEP_CFG) |=> $stable(cfg_q);
  endproperty
  a_lock_holds: assert property (p_lock_holds) // RL13
    else $error("locked config changed");

  property p_arrival_restart;
    txn_arrive[0] |=> (cnt_q[0] == 12'h000);
  endproperty
  a_arrival_restart: assert property (p_arrival_restart) // RL10
    else $error("idle counter not restarted");

  property p_wake_on_txn;
    (st_q[0] == DRPD_SLEEP && txn_arrive[0]) |=>
      (st_q[0] == DRPD_EXIT) ##1 (pins_q.cke[0] && !ready_q[0]);
  endproperty
  a_wake_on_txn: assert property (p_wake_on_txn) // RL16
    else $error("sleeping rank did not wake");

  property p_dll_exit_delay;
    (st_q[0] == DRPD_SLEEP && st_d[0] == DRPD_EXIT && dll_q[0]) |=>
      (exit_q[0] == dly_dll);
  endproperty
  a_dll_exit_delay: assert property (p_dll_exit_delay) // RL8
    else $error("dll-off exit delay wrong");

  property p_unknown_kind;
    (!kind_on && st_q[1] == DRPD_AWAKE) |=> (st_q[1] != DRPD_SLEEP);
  endproperty
  a_unknown_kind: assert property (p_unknown_kind) // RL17
    else $error("rank slept with no sleep kind");

  property p_refresh_ready;
    $rose(refresh_ready_q) |-> ($past(refresh_req) && !(|asleep));
  endproperty
  a_refresh_ready: assert property (p_refresh_ready) // RL15
    else $error("refresh ready with sleeping rank");

  property p_no_sleep_when_queued;
    txn_queued[1] |=> (st_q[1] != DRPD_SLEEP);
  endproperty
  a_no_sleep_when_queued: assert property (p_no_sleep_when_queued) // RL10
    else $error("rank slept with queued work");

  property p_populated_driven;
    (tristate_q && pop_q[0]) |=>
      (!pins_q.cke_oe_n[0] && !pins_q.cs_oe_n[0]);
  endproperty
  a_populated_driven: assert property (p_populated_driven) // RL2
    else $error("populated rank pins floated");

  property p_open_exit_delay;
    (st_q[0] == DRPD_SLEEP && st_d[0] == DRPD_EXIT && !dll_q[0]) |=>
      (exit_q[0] == dly_open);
  endproperty
  a_open_exit_delay: assert property (p_open_exit_delay) // RL7
    else $error("open-page exit delay wrong");

  property p_exit_release;
    (st_q[0] == DRPD_EXIT && exit_q[0] == 6'd0) |=>
      (st_q[0] == DRPD_AWAKE && ready_q[0]);
  endproperty
  a_exit_release: assert property (p_exit_release) // RL16
    else $error("rank not released after exit delay");

  property p_refresh_wakes;
    (refresh_req && st_q[0] == DRPD_SLEEP) |=> (st_q[0] == DRPD_EXIT);
  endproperty
  a_refresh_wakes: assert property (p_refresh_wakes) // RL15
    else $error("sleeping rank kept asleep for refresh");

  property p_close_before_sleep;
    (kind_dll && page_open[3] && st_q[3] == DRPD_AWAKE) |=>
      (st_q[3] != DRPD_SLEEP);
  endproperty
  a_close_before_sleep: assert property (p_close_before_sleep) // RL8
    else $error("rank slept with open pages in dll-off kind");

  property p_cke_off_in_sleep;
    (st_q[2] == DRPD_SLEEP) |-> !pins_q.cke[2];
  endproperty
  a_cke_off_in_sleep: assert property (p_cke_off_in_sleep) // RL4
    else $error("clock-enable high in sleep");

  c_open_sleep: cover property (st_q[0] == DRPD_SLEEP && !dll_q[0]);
  c_dll_exit: cover property (st_q[0] == DRPD_EXIT && dll_q[0]
                              ##1 st_q[0] == DRPD_AWAKE);
  c_refresh: cover property ($rose(refresh_ready_q));
  c_float: cover property (pins_q.cke_oe_n != '0);
  c_precharge: cover property (pchg_q != '0);

endmodule // drpd_top
`default_nettype wire

// *** shared/drpd_pkg.sv ***
// constants, register map and pin carrier of the rank clock-enable sleep block
// assumes one 10 MHz system clock and a slower memory clock sampled by it
package drpd_pkg;

  localparam int NUM_RANKS = 4;
  localparam int AW = 8;

  // register byte addresses
  localparam logic [7:0] REG_SLEEP_CFG = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // rank_sleep_config field layout
  localparam int KIND_LSB = 12;
  localparam int KIND_MSB = 15;
  localparam int THR_LSB = 0;
  localparam int THR_MSB = 11;
  localparam logic [15:0] CFG_RST = 16'h0000;

  // control register field layout
  localparam int CTL_TRISTATE_BIT = 0;
  localparam int CTL_LOCK_BIT = 1;
  localparam int CTL_POP_LSB = 4;
  localparam logic [3:0] POP_RST = 4'hf;

  // sleep kind encodings
  localparam logic [3:0] KIND_NONE = 4'h0;
  localparam logic [3:0] KIND_OPEN_PAGE = 4'h1;
  localparam logic [3:0] KIND_DLL_OFF = 4'h6;

  // exit delays and idle counter limit in memory clock cycles
  localparam logic [5:0] TXP_MCLK = 6'd4;
  localparam logic [5:0] TXPDLL_MCLK = 6'd20;
  localparam logic [11:0] IDLE_SAT = 12'hfff;

  typedef enum logic [1:0] {
    DRPD_AWAKE = 2'b00,
    DRPD_SLEEP = 2'b01,
    DRPD_EXIT = 2'b10
  } drpd_state_t;

  typedef struct packed {
    logic [3:0] kind;
    logic [11:0] thr;
  } drpd_cfg_t;

  typedef struct packed {
    logic [NUM_RANKS-1:0] cke;
    logic [NUM_RANKS-1:0] cke_oe_n;
    logic [NUM_RANKS-1:0] cs_n;
    logic [NUM_RANKS-1:0] cs_oe_n;
  } drpd_pins_t;

endpackage

// *** test/drpd_rank_model.sv ***
// far-side rank model: tracks which ranks hold open pages
// assumes activations and precharge requests arrive on clock
`timescale 1ns/1ns
`default_nettype none
module drpd_rank_model
  import drpd_pkg::*;
(
  input wire logic clock,
  input wire logic [NUM_RANKS-1:0] act,
  input wire logic [NUM_RANKS-1:0] pre,
  output logic [NUM_RANKS-1:0] page_open
);
  logic [NUM_RANKS-1:0] pre_q;
  initial begin
    pre_q = '0;
    page_open = '0;
  end
  // pages close one cycle late and stay open across cke low
  always @(posedge clock) begin
    pre_q <= pre;
    page_open <= (page_open | act) & ~pre_q;
  end
endmodule // drpd_rank_model
`default_nettype wire

// *** test/dram_rank_cke_power_down_tb.sv ***
// self-checking bench for drpd_top with a rank page model
// assumes 10 MHz clock and a free running 800 ns memory clock
`timescale 1ns/1ns
`default_nettype none
module dram_rank_cke_power_down_tb;
  import drpd_pkg::*;
  typedef struct {logic [15:0] cfg; logic [3:0] cke;} drpd_row_t;
  logic clock, resetn, wr_en, rd_en, mem_clk, refresh_req, refresh_ready;
  logic [AW-1:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [NUM_RANKS-1:0] arr, que, pg, csr, cmd_ready, pre;
  drpd_pins_t pins;
  int fail_count = 0;
  int checks_done = 0;
  int n, n1, n6;
  drpd_row_t rows [5] = '{'{16'h0002, 4'hf}, '{16'h1002, 4'h0},
    '{16'h3002, 4'hf}, '{16'h6080, 4'h0}, '{16'h0000, 4'hf}};

  drpd_top #(.TXP_CYC(6'd1), .TXPDLL_CYC(6'd2)) drpd_top_inst (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .mem_clk(mem_clk),
    .txn_arrive(arr), .txn_queued(que), .page_open(pg), .cs_n_req(csr),
    .refresh_req(refresh_req), .refresh_ready(refresh_ready),
    .cmd_ready(cmd_ready), .precharge_req(pre), .pins(pins));
  drpd_rank_model drpd_rank_model_inst (.clock(clock), .act(arr),
    .pre(pre), .page_open(pg));
  // counts cycles in which any rank is asked to close its pages
  int pchg_cnt = 0;
  always @(negedge clock) begin
    if (|pre) begin
      pchg_cnt++;
    end
  end

  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial begin
    mem_clk = 0;
    #130;
    forever #400 mem_clk = ~mem_clk;
  end

  task automatic final_report;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask
  // waits at falling edges so registered outputs have settled
  task automatic wait_cke(input logic [3:0] e, output int k);
    k = 0;
    while (pins.cke !== e && k < 2000) begin
      @(negedge clock);
      k++;
    end
  endtask
  // sleep rank 0, wake it, count cycles until commands are allowed
  task automatic wake(input logic [15:0] cfg, output int k);
    wr(REG_SLEEP_CFG, {16'h0000, cfg});
    wait_cke(4'h0, k);
    @(posedge clock);
    arr <= 4'h1;
    @(posedge clock);
    arr <= 4'h0;
    @(negedge clock);
    k = 0;
    while (cmd_ready[0] !== 1'b0 && k < 10) begin
      @(negedge clock);
      k++;
    end
    k = 0;
    while (cmd_ready[0] !== 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
  endtask

  initial begin
    cyc(30000);
    fail_count++;
    final_report();
  end

  initial begin
    resetn = 0;
    wr_en = 0;
    rd_en = 0;
    addr = '0;
    wdata = '0;
    arr = '0;
    que = '0;
    csr = 4'hf;
    refresh_req = 0;
    cyc(3);
    resetn <= 1'b1;
    @(negedge clock);
    chk(pins.cke, 4'h0);
    cyc(3);
    @(negedge clock);
    chk({pins.cke, cmd_ready}, 8'h0f);
    chk({pins.cke_oe_n, pins.cs_oe_n}, 8'h00);
    rd(REG_CONTROL, d);
    chk(d, 32'h000000f0);
    rd(8'h3c, d);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(REG_SLEEP_CFG, {16'h0000, rows[i].cfg});
      rd(REG_SLEEP_CFG, d);
      chk(d, {16'h0000, rows[i].cfg});
      wait_cke(rows[i].cke, n);
      cyc(20);
      @(negedge clock);
      chk(pins.cke, rows[i].cke);
    end
    wr(REG_SLEEP_CFG, 32'h1010);
    @(posedge clock);
    arr <= 4'hf;
    @(posedge clock);
    arr <= 4'h0;
    wait_cke(4'h0, n);
    chk(n >= 118 && n <= 150, 1);
    wake(16'h1002, n1);
    chk(pchg_cnt, 0);
    wake(16'h6002, n6);
    chk(pchg_cnt > 0, 1);
    chk(n1 > 0 && n1 < 40, 1);
    chk(n6 >= n1 + 8, 1);
    wait_cke(4'h0, n);
    @(posedge clock);
    refresh_req <= 1'b1;
    n = 0;
    while (refresh_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk({refresh_ready, pins.cke}, 5'h1f);
    @(posedge clock);
    refresh_req <= 1'b0;
    wait_cke(4'h0, n);
    chk(n <= 6, 1);
    @(posedge clock);
    que <= 4'h2;
    cyc(60);
    @(negedge clock);
    chk(pins.cke, 4'h2);
    @(posedge clock);
    que <= 4'h0;
    wait_cke(4'h0, n);
    chk(pins.cke, 4'h0);
    rd(REG_STATUS, d);
    chk(d, 32'h0000100f);
    cyc(1);
    @(negedge clock);
    chk(rdata, 32'h0);
    @(posedge clock);
    csr <= 4'h0;
    wr(REG_CONTROL, 32'h51);
    cyc(2);
    @(negedge clock);
    chk({pins.cke_oe_n, pins.cs_oe_n, pins.cs_n}, 12'haaa);
    wr(REG_CONTROL, 32'hf0);
    cyc(2);
    @(negedge clock);
    chk({pins.cke_oe_n, pins.cs_oe_n, pins.cs_n}, 12'h000);
    wr(REG_CONTROL, 32'hf2);
    wr(REG_SLEEP_CFG, 32'h0123);
    rd(REG_SLEEP_CFG, d);
    chk(d, 32'h6002);
    final_report();
  end
endmodule // dram_rank_cke_power_down_tb
`default_nettype wire
